// ===== src/sfdp_basic_param_rom.sv
// Serial reader for the discoverable-parameter basic table, bytes 30H to 53H
//
// Summary of operation
// - Byte 30H reads E5H; its low two bits 01b advertise uniform 4KB erase.
// - Bit 2 of byte 30H reads 1, meaning 64-byte or larger write granularity.
// - Bit 4 of byte 30H reads 0, selecting the 50H volatile write enable.
// - Bits 7:5 of byte 30H always read 111b and never change.
// - Sector type 1: size 0CH at 4CH, erase opcode 20H at 4DH.
// - Sector type 2: size 0FH at 4EH, erase opcode 52H at 4FH.
// - Sector type 3: size 10H at 50H, erase opcode D8H at 51H.
// - Sector type 4 absent: 00H at 52H; byte 53H reads 81H.
// - Bits 18:17 read 00b: array uses three address bytes only.
// - Bit 19 reads 0, no double transfer rate; byte 32H reads F1H.
// - Quad address quad data read: 44H at 38H, opcode EBH at 39H.
// - Single address quad data read: 08H at 3AH, opcode 6BH at 3BH.
// - Single address dual data read: 08H parameter, opcode 3BH at 3DH.
// - Dual address dual data read: 80H at 3EH, opcode BBH at 3FH.
// - All-dual read unsupported: 00H at 46H, FFH at 47H.
// - All-quad read supported: FEH at 40H, 44H at 4AH, EBH at 4BH.
// - The basic table starts at parameter address 30H.
module sfdp_basic_param_rom
    import sfdp_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_cs_n,
    input  wire logic i_sck,
    input  wire logic i_si,
    output logic      o_so,
    output logic      o_so_oe,
    output logic      o_reading
);

    // Whole state of the reader
    typedef struct packed {
        phase_t      phase;
        logic [4:0]  bit_cnt;
        logic [7:0]  cmd_shift;
        logic [23:0] addr;
        logic [7:0]  out_shift;
        logic        so;
        logic        so_oe;
        logic        reading;
    } reader_t;

    localparam reader_t RESET_STATE = '{
        phase:     ST_IDLE,
        bit_cnt:   5'h00,
        cmd_shift: 8'h00,
        addr:      24'h000000,
        out_shift: 8'h00,
        so:        1'b0,
        so_oe:     1'b0,
        reading:   1'b0
    };

    reader_t     cur;
    reader_t     next_cur;
    logic        sck_rise;
    logic        sck_fall;
    logic        table_hit;
    logic [23:0] table_offset;
    logic [5:0]  table_index;
    logic [7:0]  table_byte;

    // Clock edges of the serial link, seen in the system clock domain
    sfdp_sck_edges u_edges (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_sck     (i_sck),
        .o_rise    (sck_rise),
        .o_fall    (sck_fall)
    );

    // Map the running address onto the table; the base is where the header points
    assign table_hit    = (cur.addr >= TABLE_BASE) && (cur.addr <= TABLE_LAST);
    assign table_offset = cur.addr - TABLE_BASE;
    assign table_index  = table_offset[5:0];

    // The store answers a cycle late; the address is steady for a whole byte,
    // so the looked-up byte is always ready before the next load edge
    sfdp_table_rom u_rom (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_index   (table_index),
        .i_hit     (table_hit),
        .o_data    (table_byte)
    );

    // Frame sequencing: opcode, address, dummy, then bytes until chip select rises
    always_comb begin
        next_cur = cur;
        if (i_cs_n) begin
            // Raising chip select ends any phase at once and releases the pin
            next_cur.phase   = ST_IDLE;
            next_cur.bit_cnt = 5'h00;
            next_cur.so      = 1'b0;
            next_cur.so_oe   = 1'b0;
            next_cur.reading = 1'b0;
        end else begin
            case (cur.phase)
                ST_IDLE: begin
                    // Chip select just fell; the first rise is the opcode MSB
                    next_cur.phase   = ST_CMD;
                    next_cur.bit_cnt = 5'h00;
                end
                ST_CMD: begin
                    if (sck_rise) begin
                        next_cur.cmd_shift = {cur.cmd_shift[6:0], i_si};
                        if (cur.bit_cnt == CMD_LAST_BIT) begin
                            next_cur.bit_cnt = 5'h00;
                            // Only the parameter read is served; others are sat out
                            if ({cur.cmd_shift[6:0], i_si} == READ_PARAMS_OPCODE) begin
                                next_cur.phase = ST_ADDR;
                            end else begin
                                next_cur.phase = ST_IGNORE;
                            end
                        end else begin
                            next_cur.bit_cnt = cur.bit_cnt + 5'h01;
                        end
                    end
                end
                ST_ADDR: begin
                    if (sck_rise) begin
                        // Address arrives MSB first over three bytes
                        next_cur.addr = {cur.addr[22:0], i_si};
                        if (cur.bit_cnt == ADDR_LAST_BIT) begin
                            next_cur.phase   = ST_DUMMY;
                            next_cur.bit_cnt = 5'h00;
                        end else begin
                            next_cur.bit_cnt = cur.bit_cnt + 5'h01;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (sck_rise) begin
                        // Dummy bits are clocked but their value is never looked at
                        if (cur.bit_cnt == DUMMY_LAST_BIT) begin
                            next_cur.phase   = ST_DATA;
                            next_cur.bit_cnt = 5'h00;
                            next_cur.reading = 1'b1;
                        end else begin
                            next_cur.bit_cnt = cur.bit_cnt + 5'h01;
                        end
                    end
                end
                ST_DATA: begin
                    // Data changes on the falling edge so it is stable at the next rise
                    if (sck_fall) begin
                        next_cur.so_oe   = 1'b1;
                        next_cur.bit_cnt = {2'b00, cur.bit_cnt[2:0] + BIT_STEP};
                        if (cur.bit_cnt[2:0] == BYTE_FIRST_BIT) begin
                            // Load a fresh byte; reads past the table give all ones
                            next_cur.so        = table_byte[7];
                            next_cur.out_shift = {table_byte[6:0], 1'b0};
                            next_cur.addr      = cur.addr + ADDR_STEP;
                        end else begin
                            next_cur.so        = cur.out_shift[7];
                            next_cur.out_shift = {cur.out_shift[6:0], 1'b0};
                        end
                    end
                end
                ST_IGNORE: begin
                    // Foreign command: stay off the line until the frame ends
                    next_cur.so_oe = 1'b0;
                end
                default: begin
                    next_cur = RESET_STATE;
                end
            endcase
        end
    end

    // State register; reset loads constants only
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= RESET_STATE;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs come straight from the state register
    assign o_so      = cur.so;
    assign o_so_oe   = cur.so_oe;
    assign o_reading = cur.reading;

endmodule

// ===== src/sfdp_pkg.sv
// Shared constants for the discoverable-parameter basic table reader
package sfdp_pkg;

    // Serial command framing
    localparam logic [7:0] READ_PARAMS_OPCODE = 8'h5a;    // read_discoverable_params_cmd
    localparam logic [4:0] CMD_LAST_BIT       = 5'h07;    // Eight opcode bits
    localparam logic [4:0] ADDR_LAST_BIT      = 5'h17;    // Three address bytes
    localparam logic [4:0] DUMMY_LAST_BIT     = 5'h07;    // One dummy byte
    localparam logic [2:0] BYTE_FIRST_BIT     = 3'h0;
    localparam logic [2:0] BIT_STEP           = 3'h1;
    localparam logic [23:0] ADDR_STEP         = 24'h000001;

    // Where the basic table sits in the parameter address space
    localparam logic [23:0] TABLE_BASE  = 24'h000030;     // param_table_pointer target
    localparam logic [23:0] TABLE_LAST  = 24'h000053;
    localparam int          TABLE_BYTES = 36;
    localparam logic [7:0]  UNUSED_BYTE = 8'hff;

    // First byte fields, low to high
    localparam logic [1:0] ERASE_4K_UNIFORM = 2'h1;
    localparam logic       WRITE_GRAN_64    = 1'h1;
    localparam logic       VOLATILE_WE_REQ  = 1'h0;
    localparam logic       VOLATILE_WE_50   = 1'h0;       // Selects the 50H write enable
    localparam logic [2:0] UNUSED_HIGH_BITS = 3'h7;       // Fixed pattern, never altered

    // Third byte fields, low to high
    localparam logic       SUPPORT_1_1_2    = 1'h1;
    localparam logic [1:0] ADDR_3BYTE_ONLY  = 2'h0;
    localparam logic       DTR_SUPPORT      = 1'h0;
    localparam logic       SUPPORT_1_2_2    = 1'h1;
    localparam logic       SUPPORT_1_4_4    = 1'h1;
    localparam logic       SUPPORT_1_1_4    = 1'h1;
    localparam logic       UNUSED_BIT       = 1'h1;

    // Wait-state and mode-bit fields of the fast read descriptors
    localparam logic [4:0] WAIT_NONE = 5'h00;
    localparam logic [4:0] WAIT_4    = 5'h04;
    localparam logic [4:0] WAIT_8    = 5'h08;
    localparam logic [2:0] MODE_NONE = 3'h0;
    localparam logic [2:0] MODE_2    = 3'h2;
    localparam logic [2:0] MODE_4    = 3'h4;

    // Support byte for the all-dual and all-quad modes
    localparam logic SUPPORT_2_2_2 = 1'h0;
    localparam logic SUPPORT_4_4_4 = 1'h1;

    // Opcodes and sector sizes
    localparam logic [7:0] OPC_ERASE_4K  = 8'h20;
    localparam logic [7:0] OPC_ERASE_32K = 8'h52;
    localparam logic [7:0] OPC_ERASE_64K = 8'hd8;
    localparam logic [7:0] OPC_SECTOR4   = 8'h81;
    localparam logic [7:0] OPC_READ_144  = 8'heb;
    localparam logic [7:0] OPC_READ_114  = 8'h6b;
    localparam logic [7:0] OPC_READ_112  = 8'h3b;
    localparam logic [7:0] OPC_READ_122  = 8'hbb;
    localparam logic [7:0] SIZE_4K       = 8'h0c;
    localparam logic [7:0] SIZE_32K      = 8'h0f;
    localparam logic [7:0] SIZE_64K      = 8'h10;
    localparam logic [7:0] SIZE_ABSENT   = 8'h00;
    localparam logic [31:0] DENSITY      = 32'h003fffff;

    // Table bytes 30H through 53H in address order
    localparam logic [7:0] BASIC_TABLE [0:TABLE_BYTES-1] = '{
        {UNUSED_HIGH_BITS, VOLATILE_WE_50, VOLATILE_WE_REQ, WRITE_GRAN_64, ERASE_4K_UNIFORM},
        OPC_ERASE_4K,
        {UNUSED_BIT, SUPPORT_1_1_4, SUPPORT_1_4_4, SUPPORT_1_2_2, DTR_SUPPORT, ADDR_3BYTE_ONLY,
         SUPPORT_1_1_2},
        UNUSED_BYTE,
        DENSITY[7:0], DENSITY[15:8], DENSITY[23:16], DENSITY[31:24],
        {MODE_2, WAIT_4}, OPC_READ_144,
        {MODE_NONE, WAIT_8}, OPC_READ_114,
        {MODE_NONE, WAIT_8}, OPC_READ_112,
        {MODE_4, WAIT_NONE}, OPC_READ_122,
        {UNUSED_HIGH_BITS, SUPPORT_4_4_4, UNUSED_HIGH_BITS, SUPPORT_2_2_2},
        UNUSED_BYTE, UNUSED_BYTE, UNUSED_BYTE, UNUSED_BYTE, UNUSED_BYTE,
        {MODE_NONE, WAIT_NONE}, UNUSED_BYTE,
        UNUSED_BYTE, UNUSED_BYTE,
        {MODE_2, WAIT_4}, OPC_READ_144,
        SIZE_4K, OPC_ERASE_4K,
        SIZE_32K, OPC_ERASE_32K,
        SIZE_64K, OPC_ERASE_64K,
        SIZE_ABSENT, OPC_SECTOR4
    };

    // Phases of one chip-select frame
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CMD    = 3'b001,
        ST_ADDR   = 3'b010,
        ST_DUMMY  = 3'b011,
        ST_DATA   = 3'b100,
        ST_IGNORE = 3'b101
    } phase_t;

endpackage

// ===== src/sfdp_table_rom.sv
// Basic parameter table store with registered read data
module sfdp_table_rom
    import sfdp_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    input  wire logic [5:0] i_index,
    input  wire logic       i_hit,
    output logic      [7:0] o_data
);

    typedef struct packed {
        logic [7:0] data;
    } rom_t;

    rom_t cur;
    rom_t next_cur;

    // Misses return the unused pattern so gaps read as all ones
    always_comb begin
        next_cur = cur;
        if (i_hit) begin
            next_cur.data = BASIC_TABLE[i_index];
        end else begin
            next_cur.data = UNUSED_BYTE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= '{data: UNUSED_BYTE};
        end else begin
            cur <= next_cur;
        end
    end

    assign o_data = cur.data;

endmodule

// ===== src/sfdp_sck_edges.sv
// Rise and fall detection of the serial clock pin
module sfdp_sck_edges (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_sck,
    output logic      o_rise,
    output logic      o_fall
);

    typedef struct packed {
        logic sck_prev;
    } edge_t;

    edge_t cur;
    edge_t next_cur;

    // Pin is taken as synchronous, so one history flop suffices
    always_comb begin
        next_cur = cur;
        next_cur.sck_prev = i_sck;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= '{sck_prev: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign o_rise = i_sck & ~cur.sck_prev;
    assign o_fall = ~i_sck & cur.sck_prev;

endmodule

// ===== tb/sfdp_basic_param_rom_assertions.sv
// Checker of serial framing and output timing for the parameter table reader
module sfdp_basic_param_rom_assertions (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic o_so,
    input wire logic o_so_oe,
    input wire logic o_reading
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       sck_q;
    logic [5:0] rises;
    logic [7:0] op;

    // Own count of rises and opcode of the frame, kept apart from the design
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sck_q <= 1'b0;
            rises <= 6'h00;
            op    <= 8'h00;
        end else begin
            sck_q <= i_sck;
            if (i_cs_n) begin
                rises <= 6'h00;
            end else if (i_sck && !sck_q && rises != 6'h3f) begin
                rises <= rises + 6'h01;  // Saturates so long reads never wrap
            end
            if (i_sck && !sck_q && !i_cs_n && rises < 6'h08) begin
                op <= {op[6:0], i_si};
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_idle_no_drive: assert property (i_cs_n |=> !o_so_oe)
        else $error("output enable high after deselect");
    a_idle_no_status: assert property (i_cs_n |=> !o_reading)
        else $error("reading flag high after deselect");
    a_so_quiet: assert property (!o_so_oe |-> !o_so)
        else $error("data line not low while released");
    // Enable stands one cycle past the rise of chip select, so look at the cycle before
    a_oe_in_data: assert property (o_so_oe |-> o_reading && !$past(i_cs_n))
        else $error("output enable outside the data phase");
    a_so_after_fall: assert property ($changed(o_so) && o_so_oe && $past(o_so_oe) |-> !$past(i_sck))
        else $error("data bit changed without a clock fall");
    a_oe_start: assert property ($rose(o_so_oe) |-> !$past(i_sck) && rises == 6'h28)
        else $error("output enable rose at the wrong moment");
    a_reading_count: assert property ($rose(o_reading) |-> rises == 6'h28)
        else $error("data phase began after the wrong rise count");
    a_opcode_gate: assert property (o_reading |-> op == 8'h5a)
        else $error("data phase entered for a foreign opcode");
    a_reading_hold: assert property (o_reading && !i_cs_n |=> o_reading [*1])
        else $error("reading flag dropped inside the frame");

    c_data_start: cover property ($rose(o_so_oe));
    c_reading: cover property ($rose(o_reading));
    c_abort: cover property (o_so_oe && i_cs_n);
endmodule

bind sfdp_basic_param_rom sfdp_basic_param_rom_assertions u_chk (
    .i_clk_sys(i_clk_sys),
    .i_rst_n  (i_rst_n),
    .i_cs_n   (i_cs_n),
    .i_sck    (i_sck),
    .i_si     (i_si),
    .o_so     (o_so),
    .o_so_oe  (o_so_oe),
    .o_reading(o_reading)
);

// ===== tb/sfdp_host_model.sv
// Host controller model issuing parameter-table reads in clock mode 0
module sfdp_host_model (
    input  wire logic i_clk_sys,
    input  wire logic i_so,
    input  wire logic i_so_oe,
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rx [0:63];
    logic       saw_oe;

    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_si   = 1'b0;
        saw_oe = 1'b0;
    end

    // Remembers whether the device drove the data line in this frame
    always @(posedge i_clk_sys) begin
        if (i_so_oe === 1'b1) begin
            saw_oe = 1'b1;
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk_sys);
        #2;
    endtask

    // One frame of nbits clock pulses; a count short of a byte end aborts mid-byte
    task automatic frame(input logic [7:0] opc, input logic [23:0] adr, input int nbits);
        logic [39:0] hdr;
        hdr = {opc, adr, 8'h00};
        saw_oe = 1'b0;
        cyc(1);
        o_cs_n = 1'b0;  // Clock is low as select falls
        for (int i = 0; i < nbits; i++) begin
            cyc(3);
            o_si = (i < 40) ? hdr[39-i] : ~o_si;  // Line toggles once the header is sent
            cyc(1);
            if (i >= 40) begin
                // A released line reads as the inverse, so a late enable shows up
                rx[(i-40)/8][7-(i%8)] = (i_so_oe === 1'b1) ? i_so : ~i_so;
            end
            o_sck = 1'b1;
            cyc(4);
            o_sck = 1'b0;
        end
        cyc(4);
        o_cs_n = 1'b1;
        cyc(2);
    endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the parameter table reader
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk_sys = 1'b0;
    logic i_rst_n   = 1'b0;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic reading;
    int   num_errors = 0;
    int   compares   = 0;

    always #12.5 i_clk_sys = ~i_clk_sys;

    sfdp_basic_param_rom u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cs_n(cs_n), .i_sck(sck),
        .i_si(si), .o_so(so), .o_so_oe(so_oe), .o_reading(reading));
    sfdp_host_model u_host (.i_clk_sys(i_clk_sys), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n),
        .o_sck(sck), .o_si(si));

    task automatic t_table();
        u_host.frame(8'h5a, 24'h000030, 40 + 36 * 8);
        `CHECK(u_host.rx[0], 8'he5)
        `CHECK({u_host.rx[1], u_host.rx[2], u_host.rx[3]}, 24'h20f1ff)
        `CHECK({u_host.rx[8], u_host.rx[9], u_host.rx[10], u_host.rx[11]}, 32'h44eb086b)
        `CHECK({u_host.rx[12], u_host.rx[13], u_host.rx[14], u_host.rx[15]}, 32'h083b80bb)
        `CHECK(u_host.rx[16], 8'hfe)
        `CHECK({u_host.rx[22], u_host.rx[23]}, 16'h00ff)
        `CHECK({u_host.rx[26], u_host.rx[27]}, 16'h44eb)
        `CHECK({u_host.rx[28], u_host.rx[29], u_host.rx[30], u_host.rx[31]}, 32'h0c200f52)
        `CHECK({u_host.rx[32], u_host.rx[33], u_host.rx[34], u_host.rx[35]}, 32'h10d80081)
        for (int k = 17; k < 26; k++) begin
            if (k != 22 && k != 23) begin
                `CHECK(u_host.rx[k], 8'hff)
            end
        end
        $display("Test table done");
    endtask

    // Reads that straddle both ends of the table
    task automatic t_edges();
        u_host.frame(8'h5a, 24'h00002f, 40 + 16);
        `CHECK({u_host.rx[0], u_host.rx[1]}, 16'hffe5)
        u_host.frame(8'h5a, 24'h000052, 40 + 24);
        `CHECK({u_host.rx[0], u_host.rx[1], u_host.rx[2]}, 24'h0081ff)
        $display("Test edges done");
    endtask

    task automatic t_bad_opcode();
        u_host.frame(8'h03, 24'h000030, 40 + 8);
        `CHECK(u_host.saw_oe, 1'b0)
        $display("Test foreign opcode done");
    endtask

    // Abort in mid-byte, then a frame at once after it
    task automatic t_abort();
        u_host.frame(8'h5a, 24'h00004c, 44);
        `CHECK(u_host.saw_oe, 1'b1)
        `CHECK(so_oe, 1'b0)
        u_host.frame(8'h5a, 24'h00004d, 48);
        `CHECK(u_host.rx[0], 8'h20)
        $display("Test abort done");
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge i_clk_sys);
        #2;
        i_rst_n = 1'b1;
        t_table();
        t_edges();
        t_bad_opcode();
        t_abort();
        give_verdict();
    end

    // The whole run needs under 6000 cycles; a hang ends it here
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        num_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        give_verdict();
    end
endmodule
